// ===== rtl/scv_pkg.sv
package scv_pkg;
	// ***********************************************
	// data format
	// ***********************************************
	localparam int RESULT_BITS       = 14;
	localparam logic [13:0] ZERO_CODE = 14'h0000;   // bipolar codes flip around zero
	localparam logic [3:0] MSB_INDEX = 4'hd;

	// ***********************************************
	// timing, in nanoseconds, and cycle counts at 100 MHz
	// ***********************************************
	localparam int CLK_PERIOD_NS     = 10;
	localparam int ACQ_CONV_MAX_NS   = 2500;        // acquire plus convert
	localparam int ACQ_MIN_NS        = 500;
	localparam int CONVERT_START_N_QUIET_NS   = 625;
	localparam int NAP_WAKE_NS       = 500;
	localparam int CONV_CYCLES       = (ACQ_CONV_MAX_NS - ACQ_MIN_NS) / CLK_PERIOD_NS;
	localparam int CONVERT_START_N_QUIET_CYC  = CONVERT_START_N_QUIET_NS / CLK_PERIOD_NS;
	localparam int NAP_WAKE_CYC      = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INT_CLK_HALF      = 5;           // 100 MHz / 10 = 10 MHz, nearest to 9.4
	localparam int EXT_CLK_BITS      = 14;          // one comparison per conversion clock
	localparam int EXT_WAIT_NS       = 20000;
	localparam int EXT_WAIT_CYC      = EXT_WAIT_NS / CLK_PERIOD_NS;

	// ***********************************************
	// power modes
	// ***********************************************
	typedef enum logic [1:0] {
		SCV_RUN,
		SCV_NAP,
		SCV_SLEEP
	} scv_power_e;
endpackage

// ===== rtl/scv_link_if.sv
`timescale 1ns/100ps
interface scv_link_if;
	logic convert_start_n;
	logic busy_n;
	logic read_n;
	logic power_down_n;
	logic shift_clk;
	logic data_out;
	logic data_out_oe;
	logic conversion_clock_in;
	logic conversion_clock_out;
	logic conversion_clock_out_oe;

	modport converter (
		input  convert_start_n, read_n, power_down_n, shift_clk, conversion_clock_in,
		output busy_n, data_out, data_out_oe, conversion_clock_out, conversion_clock_out_oe
	);
	modport controller (
		output convert_start_n, read_n, power_down_n, shift_clk, conversion_clock_in,
		input  busy_n, data_out, data_out_oe, conversion_clock_out, conversion_clock_out_oe
	);
endinterface

// ===== rtl/scv_converter.sv
`timescale 1ns/100ps
module scv_converter
	import scv_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES,
	parameter int EXT_WAIT = EXT_WAIT_CYC,
	parameter int SEL_CYC  = 64               // clock-in high this long selects internal
) (
	// system
	input  wire logic                   clk_sys,
	input  wire logic                   reset_n,
	// link
	scv_link_if.converter               link,
	// analog sample stand-in and status
	input  wire logic [RESULT_BITS-1:0] sample_code,
	output logic [RESULT_BITS-1:0]      last_result,
	output scv_power_e                  power_mode,
	output logic                        internal_clock
);
	// ***********************************************
	// input synchronisers
	// ***********************************************
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	logic [4:0] sync_d;
	always_ff @(posedge clk_sys) begin
		sync_a <= {link.convert_start_n, link.read_n, link.power_down_n,
		           link.shift_clk, link.conversion_clock_in};
		sync_b <= sync_a;
		sync_d <= sync_b;
	end
	wire logic cs_n   = sync_b[4];
	wire logic rd_n   = sync_b[3];
	wire logic pd_n   = sync_b[2];
	wire logic sck    = sync_b[1];
	wire logic eck    = sync_b[0];
	wire logic cs_fall  = sync_d[4] & ~cs_n;
	wire logic pd_fall  = sync_d[2] & ~pd_n;
	wire logic sck_fall = sync_d[1] & ~sck;
	wire logic eck_rise = ~sync_d[0] & eck;

	// ***********************************************
	// clock source selection
	// ***********************************************
	// a free-running external clock never stays high long; a strap does
	logic [15:0] high_cnt;
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !eck) begin
			high_cnt       <= 16'h0000;
			internal_clock <= 1'b0;
		end else if (high_cnt < 16'(SEL_CYC)) begin
			high_cnt <= high_cnt + 16'h0001;
		end else begin
			internal_clock <= 1'b1;
		end
	end

	// internal oscillator stand-in divided from clk_sys
	logic [3:0] div_cnt;
	logic       int_clk;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			div_cnt <= 4'h0;
			int_clk <= 1'b0;
		end else if (div_cnt == 4'(INT_CLK_HALF - 1)) begin
			div_cnt <= 4'h0;
			int_clk <= ~int_clk;
		end else begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// mirror output: internal divider or the sampled external clock
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			link.conversion_clock_out <= 1'b0;
		else if (internal_clock)
			link.conversion_clock_out <= int_clk;
		else
			link.conversion_clock_out <= eck;
	end
	assign link.conversion_clock_out_oe = ~rd_n;   // drivers float while read is high

	// ***********************************************
	// power modes
	// ***********************************************
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			power_mode <= SCV_RUN;
		else if (pd_fall)
			power_mode <= rd_n ? SCV_SLEEP : SCV_NAP;
		else if (pd_n)
			power_mode <= SCV_RUN;
	end

	// ***********************************************
	// conversion sequencer
	// ***********************************************
	typedef enum logic [1:0] {
		SCV_IDLE,
		SCV_CONV_INT,
		SCV_CONV_EXT
	} scv_conv_e;
	scv_conv_e   state;
	logic [15:0] conv_cnt;
	logic [3:0]  ext_bits;
	logic        finish;
	always_ff @(posedge clk_sys) begin
		finish <= 1'b0;
		if (!reset_n) begin
			state    <= SCV_IDLE;
			conv_cnt <= 16'h0000;
			ext_bits <= 4'h0;
		end else begin
			case (state)
				SCV_IDLE: begin
					conv_cnt <= 16'h0000;
					ext_bits <= 4'h0;
					if (cs_fall && power_mode == SCV_RUN)
						state <= internal_clock ? SCV_CONV_INT : SCV_CONV_EXT;
				end
				SCV_CONV_INT: begin
					conv_cnt <= conv_cnt + 16'h0001;
					if (conv_cnt == 16'(CONV_CYC - 1)) begin
						finish <= 1'b1;
						state  <= SCV_IDLE;
					end
				end
				SCV_CONV_EXT: begin
					conv_cnt <= conv_cnt + 16'h0001;
					if (eck_rise)
						ext_bits <= ext_bits + 4'h1;
					// external clock supplies one comparison per rising edge
					if ((eck_rise && ext_bits == 4'(EXT_CLK_BITS - 1))
					    || (ext_bits == 4'h0 && conv_cnt == 16'(EXT_WAIT))) begin
						finish <= 1'b1;
						state  <= SCV_IDLE;
					end
				end
				default: state <= SCV_IDLE;
			endcase
		end
	end

	// result latched one cycle before busy rises
	wire logic latch_now = state != SCV_IDLE && !finish && (
	           (state == SCV_CONV_INT && conv_cnt == 16'(CONV_CYC - 1)) ||
	           (state == SCV_CONV_EXT && eck_rise && ext_bits == 4'(EXT_CLK_BITS - 1)));
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			last_result <= ZERO_CODE;
		else if (latch_now)
			last_result <= sample_code;
	end

	// busy low from start through the cycle the result settles
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			link.busy_n <= 1'b1;
		else
			link.busy_n <= !(state != SCV_IDLE && !finish) && !(state == SCV_IDLE && cs_fall
			               && power_mode == SCV_RUN);
	end

	// ***********************************************
	// serial read-out
	// ***********************************************
	logic [RESULT_BITS-1:0] shifter;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			shifter       <= ZERO_CODE;
			link.data_out <= 1'b0;
		end else begin
			// load with the result so the msb stands on the pin before busy rises
			if (latch_now) begin
				shifter       <= {sample_code[RESULT_BITS-2:0], 1'b0};
				link.data_out <= sample_code[MSB_INDEX];
			end else if (sck_fall && !rd_n) begin
				// bit only moves after the falling edge has been synchronised
				link.data_out <= shifter[MSB_INDEX];
				shifter       <= {shifter[RESULT_BITS-2:0], 1'b0};
			end
		end
	end
	assign link.data_out_oe = ~rd_n;
endmodule

// ===== rtl/scv_controller.sv
`timescale 1ns/100ps
module scv_controller
	import scv_pkg::*;
#(
	parameter int SCK_HALF = 8,              // 6.25 MHz, 50% duty: bit crosses both syncs
	parameter int EXT_HALF = 6               // external conversion clock ~8.3 MHz
) (
	// system
	input  wire logic                   clk_sys,
	input  wire logic                   reset_n,
	// link
	scv_link_if.controller              link,
	// user side
	input  wire logic                   start,
	input  wire logic                   use_external,
	input  wire logic                   power_down,
	output logic [RESULT_BITS-1:0]      result,
	output logic                        result_valid,
	output logic                        ready
);
	// ***********************************************
	// synchronised returns
	// ***********************************************
	logic [1:0] s1;
	logic [1:0] s2;
	logic [1:0] s3;
	always_ff @(posedge clk_sys) begin
		s1 <= {link.busy_n, link.data_out};
		s2 <= s1;
		s3 <= s2;
	end
	wire logic busy_rise = s2[1] & ~s3[1];

	// external conversion clock from a divider; strapped high otherwise
	logic [3:0] ediv;
	logic       eclk;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ediv <= 4'h0;
			eclk <= 1'b0;
		end else if (ediv == 4'(EXT_HALF - 1)) begin
			ediv <= 4'h0;
			eclk <= ~eclk;
		end else begin
			ediv <= ediv + 4'h1;
		end
	end
	assign link.conversion_clock_in = use_external ? eclk : 1'b1;

	// ***********************************************
	// sequence
	// ***********************************************
	typedef enum logic [2:0] {
		SCC_IDLE,
		SCC_LOW,
		SCC_WAIT,
		SCC_SHIFT,
		SCC_WAKE
	} scc_state_e;
	scc_state_e  state;
	logic [15:0] cnt;
	logic [4:0]  bits;
	logic [3:0]  sdiv;
	always_ff @(posedge clk_sys) begin
		result_valid <= 1'b0;
		if (!reset_n) begin
			state                <= SCC_IDLE;
			cnt                  <= 16'h0000;
			bits                 <= 5'h00;
			sdiv                 <= 4'h0;
			result               <= ZERO_CODE;
			link.convert_start_n <= 1'b1;
			link.read_n          <= 1'b1;
			link.shift_clk       <= 1'b0;
			link.power_down_n    <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			case (state)
				SCC_IDLE: begin
					link.read_n <= ~power_down;            // nap if powered down
					if (power_down) begin
						link.power_down_n <= 1'b0;
					end else if (!link.power_down_n) begin
						link.power_down_n <= 1'b1;
						cnt               <= 16'h0000;
						state             <= SCC_WAKE;
					end else if (start) begin
						link.convert_start_n <= 1'b0;
						cnt                  <= 16'h0000;
						state                <= SCC_LOW;
					end
				end
				SCC_WAKE: if (cnt == 16'(NAP_WAKE_CYC)) state <= SCC_IDLE;
				SCC_LOW: if (cnt == 16'(CONVERT_START_N_QUIET_CYC / 2)) begin
					link.convert_start_n <= 1'b1;
					state                <= SCC_WAIT;
				end
				SCC_WAIT: if (busy_rise) begin
					link.read_n <= 1'b0;
					bits        <= 5'h00;
					sdiv        <= 4'h0;
					state       <= SCC_SHIFT;
				end
				SCC_SHIFT: begin
					sdiv <= sdiv + 4'h1;
					if (sdiv == 4'(SCK_HALF - 1)) begin
						sdiv           <= 4'h0;
						link.shift_clk <= ~link.shift_clk;
						if (!link.shift_clk) begin
							// rising edge: capture the bit present since last fall
							result <= {result[RESULT_BITS-2:0], s2[0]};
							bits   <= bits + 5'h01;
						end else if (bits == 5'(RESULT_BITS)) begin
							link.read_n  <= 1'b1;
							result_valid <= 1'b1;
							state        <= SCC_IDLE;
						end
					end
				end
				default: state <= SCC_IDLE;
			endcase
		end
	end
	// a start is only taken when awake and not about to nap
	assign ready = (state == SCC_IDLE) && link.power_down_n && !power_down;
endmodule

// ===== testbench/scv_link_sva.sv
`timescale 1ns/100ps
// ***********************************************
// link timing checks between the two ends
// ***********************************************
module scv_link_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// link signals
	input wire logic convert_start_n,
	input wire logic busy_n,
	input wire logic read_n,
	input wire logic power_down_n,
	input wire logic shift_clk,
	input wire logic data_out,
	input wire logic data_out_oe,
	input wire logic conversion_clock_out_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	logic [7:0] fall_age;
	logic [7:0] wake_age;

	// cycles since shift clock fell; saturates so old edges never wrap
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			fall_age <= 8'hff;
		else if ($fell(shift_clk))
			fall_age <= 8'h00;
		else if (fall_age != 8'hff)
			fall_age <= fall_age + 8'h01;
	end

	// cycles since power-down released; starts saturated so reset is no wake
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			wake_age <= 8'hff;
		else if ($rose(power_down_n))
			wake_age <= 8'h00;
		else if (wake_age != 8'hff)
			wake_age <= wake_age + 8'h01;
	end

	chk_start_busy: assert property (
		$fell(convert_start_n) && busy_n && power_down_n |-> ##[2:6] !busy_n)
		else $error("busy did not follow start");
	chk_busy_hold: assert property ($fell(busy_n) |-> !busy_n [*8])
		else $error("busy released too soon");
	chk_conv_bound: assert property ($fell(busy_n) |-> ##[8:250] busy_n)
		else $error("conversion too long");
	chk_start_release: assert property (
		$fell(convert_start_n) |-> ##[1:62] convert_start_n)
		else $error("start held low too long");
	chk_wake_gap: assert property (
		$fell(convert_start_n) |-> wake_age >= 8'd48)
		else $error("start too soon after wake");
	chk_read_after: assert property ($fell(read_n) |-> busy_n)
		else $error("read during conversion");
	chk_shift_half: assert property ($rose(shift_clk) |-> shift_clk [*5])
		else $error("shift clock high phase short");
	chk_data_timing: assert property (
		$changed(data_out) && !read_n && busy_n && $past(busy_n) && power_down_n
		|-> fall_age inside {[8'd1:8'd6]})
		else $error("serial bit moved off its edge");
	chk_oe_follow: assert property ($fell(read_n) |-> ##[1:4] data_out_oe)
		else $error("output not enabled by read");
	chk_float_idle: assert property (
		$rose(read_n) |-> ##[1:4] (!data_out_oe && !conversion_clock_out_oe))
		else $error("outputs still driven after read");

	cover property ($fell(busy_n));
	cover property ($rose(power_down_n));
	cover property ($fell(shift_clk) && !read_n);
	cover property ($rose(read_n) && power_down_n);
endmodule

// ===== testbench/test_sar_adc_conversion_serial_timing.sv
`timescale 1ns/100ps
// ***********************************************
// bench: converter and controller joined by the link
// ***********************************************
module test_sar_adc_conversion_serial_timing;
	import scv_pkg::*;
	logic        clk_sys      = 1'b0;
	logic        reset_n      = 1'b0;
	logic        start        = 1'b0;
	logic        use_external = 1'b0;
	logic        power_down   = 1'b0;
	logic [13:0] sample_code  = 14'h0000;
	logic [13:0] result;
	logic [13:0] last_result;
	logic        result_valid;
	logic        ready;
	logic        internal_clock;
	scv_power_e  power_mode;
	logic [13:0] exp_q[$];
	logic [13:0] codes[4]     = '{14'h0000, 14'h3fff, 14'h1fff, 14'h2000};
	int          err_total    = 0;
	int          n_tests      = 0;
	int          seed         = 33683;
	int          cyc_count    = 0;
	localparam int SCK_HALF   = 8;      // shift clock half period in clk cycles
	localparam int EXT_HALF   = 6;      // external conversion clock half period

	scv_link_if link ();

	always #5 clk_sys = ~clk_sys;

	// short strap and timeout counts keep the run brief
	scv_converter #(.SEL_CYC(8), .EXT_WAIT(200)) i_scv_converter (.clk_sys(clk_sys),
		.reset_n(reset_n), .link(link), .sample_code(sample_code),
		.last_result(last_result), .power_mode(power_mode), .internal_clock(internal_clock));
	scv_controller #(.SCK_HALF(SCK_HALF), .EXT_HALF(EXT_HALF)) i_scv_controller (
		.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
		.start(start), .use_external(use_external), .power_down(power_down),
		.result(result), .result_valid(result_valid), .ready(ready));
	scv_link_sva i_scv_link_sva (.clk_sys(clk_sys), .reset_n(reset_n),
		.convert_start_n(link.convert_start_n), .busy_n(link.busy_n), .read_n(link.read_n),
		.power_down_n(link.power_down_n), .shift_clk(link.shift_clk),
		.data_out(link.data_out), .data_out_oe(link.data_out_oe),
		.conversion_clock_out_oe(link.conversion_clock_out_oe));

	task check(input logic [13:0] seen, input logic [13:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// bounded wait for the controller to go idle
	task wait_ready;
		int i;
		for (i = 0; i < 3000 && ready !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		check(14'(ready), 14'h0001);
	endtask

	// one conversion; code held until the result is back
	task convert(input logic [13:0] code);
		int i;
		wait_ready();
		sample_code = code;
		start = 1'b1;
		exp_q.push_back(code);
		@(posedge clk_sys);
		#1;
		start = 1'b0;
		for (i = 0; i < 3000 && result_valid !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		check(14'(result_valid), 14'h0001);
		check(last_result, code);
	endtask

	// clk cycles between two rises of the mirrored conversion clock
	task clock_period(output int cyc);
		int   i;
		int   rises;
		logic prev;
		rises = 0;
		cyc   = 0;
		prev  = link.conversion_clock_out;
		for (i = 0; i < 100 && rises < 2; i++) begin
			@(posedge clk_sys);
			#1;
			if (rises == 1)
				cyc++;
			if (link.conversion_clock_out === 1'b1 && prev === 1'b0)
				rises++;
			prev = link.conversion_clock_out;
		end
	endtask

	// monitor: every serial result against the oldest note
	always @(posedge clk_sys) begin
		if (result_valid === 1'b1)
			check(result, exp_q.size() > 0 ? exp_q.pop_front() : ~result);
	end

	initial begin
		repeat (10) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
		check(14'(internal_clock), 14'h0001);
		clock_period(cyc_count);
		check(14'(cyc_count), 14'(2 * INT_CLK_HALF));
		foreach (codes[k]) convert(codes[k]);
		repeat (4) convert(14'($random(seed)));
		$display("internal clock conversions done");
		use_external = 1'b1;
		repeat (100) @(posedge clk_sys);
		#1;
		check(14'(internal_clock), 14'h0000);
		clock_period(cyc_count);
		check(14'(cyc_count), 14'(2 * EXT_HALF));
		repeat (4) convert(14'($random(seed)));
		$display("external clock conversions done");
		use_external = 1'b0;
		repeat (40) @(posedge clk_sys);
		#1;
		wait_ready();
		power_down = 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
		check(14'(power_mode), 14'(SCV_NAP));
		power_down = 1'b0;
		convert(14'h2aaa);
		$display("nap wake conversion done");
		give_verdict();
	end

	// watchdog well past the expected run length
	initial begin
		#500000;
		err_total++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule
